// ==== dv/testbench.sv ====
`include "wdrt_defs.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdrt_pkg::*;
   logic clk_in, rstn_in, ce_in, wr_in, rd_in, in_system_programming_mode;
   logic watchdog_reset_out;
   wdrt_addr_type addr_in;
   wdrt_byte_type wdata_in, rdata_out, v;
   int err_count, n_compared, n, m;

   wdrt_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .in_system_programming_mode_in(in_system_programming_mode),
      .rdata_out(rdata_out), .watchdog_reset_out(watchdog_reset_out));

   // Free-running 100 MHz clock.
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One write cycle followed by an idle cycle.
   task automatic wr(input wdrt_addr_type a, input wdrt_byte_type d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask : wr

   // One read cycle; the data are checked mid-way through the next cycle.
   task automatic rd(input wdrt_addr_type a, input wdrt_byte_type exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk(rdata_out, exp);
      @(posedge clk_in);
   endtask : rd

   // Control reads back without the clear and reserved bits.
   function automatic wdrt_byte_type ctl_exp(input wdrt_byte_type d);
      return d & 8'hB7;
   endfunction : ctl_exp

   // Cycles from a clearing write until the reset output is seen high.
   function automatic int ovf_exp(input wdrt_byte_type d);
      int c;
      c = `WDRT_BASE_TICK_CYCLES * (int'(d[2:0]) + 1);
      if (!d[5] || d[4]) begin
         c = c * `WDRT_STAGE2_MOD;
      end
      if (!d[4]) begin
         c = c * `WDRT_STAGE3_MOD * `WDRT_STAGE3_MOD;
      end
      // The reset output rises one cycle after the final tick.
      return c + 1;
   endfunction : ovf_exp

   // Counts falling edges while the reset output stays at lvl, up to lim.
   task automatic hold_count(input logic lvl, input int lim, inout int c);
      do begin
         @(negedge clk_in);
         c++;
      end while (watchdog_reset_out === lvl && c < lim);
   endtask : hold_count

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // Main sequence of tests.
   initial begin
      {rstn_in, wr_in, rd_in, in_system_programming_mode} = 4'h0;
      ce_in = 1'b1;
      addr_in = 16'h0000;
      wdata_in = 8'h00;
      void'($urandom(32094));
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      rd(16'hFF36, 8'h00);
      rd(16'hFF3E, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 12; i++) begin
         v = (i < 4) ? 8'hFF >> (2 * i) : 8'($urandom);
         wr(16'hFF36, v);
         rd(16'hFF36, ctl_exp(v));
         rd(16'hFF3E, {7'h00, v[7]});
         wr({8'hFE, 8'($urandom)}, 8'hFF);
         rd({8'hFE, 8'($urandom)}, 8'h00);
         rd(16'hFF36, ctl_exp(v));
      end
      $display("field and unmapped test done");
      wr(16'hFF36, 8'hC3);
      rd(16'hFF36, 8'h83);
      in_system_programming_mode <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd(16'hFF3E, 8'h02);
      rd(16'hFF36, 8'h83);
      in_system_programming_mode <= 1'b0;
      repeat (4) @(posedge clk_in);
      rd(16'hFF3E, 8'h01);
      $display("clear and programming mode test done");
      ce_in <= 1'b0;
      wr(16'hFF36, 8'h00);
      ce_in <= 1'b1;
      rd(16'hFF36, 8'h83);
      repeat (3000) @(negedge clk_in);
      chk({7'h00, watchdog_reset_out}, 8'h00);
      @(posedge clk_in);
      $display("enable hold test done");
      // Overflow: both bypassed, third bypassed, both bypassed again.
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? 8'hF0 : {(k == 1) ? 5'h1A : 5'h1E, 3'($urandom)};
         wr(16'hFF36, v);
         n = 0;
         hold_count(1'b0, 25000, n);
         chk(n, ovf_exp(v));
         if (watchdog_reset_out !== 1'b1) begin
            finish_test();
         end
         @(posedge clk_in);
         rd(16'hFF36, 8'h00);
         rd(16'hFF3E, 8'h04);
         // Four cycles of the pulse passed while the two reads ran.
         m = 4;
         hold_count(1'b1, 40, m);
         chk(m, `WDRT_RESET_HOLD_CYCLES);
         if (watchdog_reset_out !== 1'b0) begin
            finish_test();
         end
         @(posedge clk_in);
         rd(16'hFF36, 8'h00);
      end
      $display("overflow test done");
      in_system_programming_mode <= 1'b1;
      repeat (4) @(posedge clk_in);
      wr(16'hFF36, 8'hF0);
      n = 0;
      hold_count(1'b0, 2700, n);
      chk(n, 2700);
      @(posedge clk_in);
      wr(16'hFF36, 8'h00);
      in_system_programming_mode <= 1'b0;
      $display("programming mode hold test done");
      finish_test();
   end
endmodule : testbench

`default_nettype wire

// ==== dv/wdrt_asserts.sv ====
`include "wdrt_defs.svh"
`default_nettype none

module wdrt_asserts (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire wdrt_pkg::wdrt_addr_type addr_in,
   input wire wdrt_pkg::wdrt_byte_type wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic in_system_programming_mode_in,
   input wire wdrt_pkg::wdrt_byte_type rdata_out,
   input wire logic watchdog_reset_out
);
   import wdrt_pkg::*;
   logic [4:0] hi_q;
   wire ctl_w = addr_in == `WDRT_CTRL_ADDR;
   wire map_w = ctl_w || addr_in == `WDRT_STAT_ADDR;
   wire rd_w = ce_in && rd_in;
   wire rst_w = watchdog_reset_out;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   // Counts how long the reset pulse has stood, frozen with the enable.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hi_q <= 5'h00;
      end else if (ce_in) begin
         hi_q <= rst_w ? hi_q + 5'h01 : 5'h00;
      end
   end

   AST_RST_LEN: assert property ($fell(rst_w) |-> hi_q == 5'h10)
      else $error("reset pulse ended at the wrong length");
   AST_RST_MAX: assert property (hi_q <= 5'h10)
      else $error("reset pulse too long");
   AST_RD_IDLE: assert property (
      ce_in && !rd_in |=> rdata_out == 8'h00)
      else $error("read data not idle");
   AST_RSVD: assert property (
      rd_w && ctl_w |=> !rdata_out[6] && !rdata_out[3])
      else $error("clear or reserved bit read back");
   AST_UNMAP: assert property (
      rd_w && !map_w |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   AST_OFF: assert property (
      ce_in && wr_in && ctl_w && !wdata_in[7]
      |=> (!rst_w |=> (!rst_w)[*8]))
      else $error("reset while disabled");
   AST_ISP: assert property (
      (ce_in && in_system_programming_mode_in)[*5] ##0 !rst_w |=> !rst_w)
      else $error("reset in programming mode");
   AST_RST_CLR: assert property (
      rd_w && ctl_w && rst_w |=> rdata_out == 8'h00)
      else $error("control not cleared by overflow");
endmodule : wdrt_asserts

bind wdrt_top wdrt_asserts u_asserts (
   .clk_in(clk_in),
   .rstn_in(rstn_in),
   .ce_in(ce_in),
   .addr_in(addr_in),
   .wdata_in(wdata_in),
   .wr_in(wr_in),
   .rd_in(rd_in),
   .in_system_programming_mode_in(in_system_programming_mode_in),
   .rdata_out(rdata_out),
   .watchdog_reset_out(watchdog_reset_out)
);

`default_nettype wire

// ==== verilog/wdrt_defs.svh ====
`ifndef WDRT_DEFS_SVH
`define WDRT_DEFS_SVH

// Register offsets on the sixteen-bit register port.
`define WDRT_CTRL_ADDR 16'hFF36
`define WDRT_STAT_ADDR 16'hFF3E

// Control register field positions.
`define WDRT_EN_BIT 7
`define WDRT_CLR_BIT 6
`define WDRT_BYP2_BIT 5
`define WDRT_BYP3_BIT 4
`define WDRT_RSVD_BIT 3
`define WDRT_FIRST_STAGE_COUNT_MSB 2
`define WDRT_FIRST_STAGE_COUNT_LSB 0

// Status register field positions.
`define WDRT_STAT_RUN_BIT 0
`define WDRT_STAT_ISP_BIT 1
`define WDRT_STAT_FIRE_BIT 2

// Reset values.
`define WDRT_CTRL_RESET 8'h00
`define WDRT_RDATA_RESET 8'h00

// Timing: the system clock period and the base tick of the chain.
`define WDRT_CLK_PERIOD_NS 10
`define WDRT_BASE_TICK_NS 250
`define WDRT_BASE_TICK_CYCLES (`WDRT_BASE_TICK_NS / `WDRT_CLK_PERIOD_NS)

// Modulus of the second stage, and of each of the two dividers that make
// up the third stage, so a full chain spans base * N * 100 * 10000 cycles.
`define WDRT_STAGE2_MOD 8'h64
`define WDRT_STAGE3_MOD 8'h64

// Length of the device reset pulse, in clock cycles.
`define WDRT_RESET_HOLD_CYCLES 16

`endif

// ==== verilog/wdrt_pkg.sv ====
`default_nettype none

package wdrt_pkg;
   typedef logic [15:0] wdrt_addr_type;
   typedef logic [7:0] wdrt_byte_type;
   typedef logic [7:0] wdrt_count_type;
   typedef enum logic [0:0] {
      WDRT_ST_RUN,
      WDRT_ST_FIRE
   } wdrt_state_type;
endpackage : wdrt_pkg

`default_nettype wire

// ==== verilog/wdrt_stage.sv ====
`default_nettype none

// One counter stage: passes one tick on for every modulus ticks it takes.
module wdrt_stage (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic clear_in,
   input wire logic tick_in,
   input wire wdrt_pkg::wdrt_count_type modulus_in,
   output logic tick_out
);
   import wdrt_pkg::*;

   wdrt_count_type count_q;
   wdrt_count_type count_d;
   logic wrap;

   // The stage wraps on the tick that completes its modulus.
   assign wrap = (count_q >= (modulus_in - 8'h01));
   assign tick_out = tick_in & wrap;
   assign count_d = clear_in ? 8'h00 :
                    !tick_in ? count_q :
                    wrap ? 8'h00 : count_q + 8'h01;

   // Count register, frozen while the clock enable is low.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_q <= 8'h00;
      end else if (ce_in) begin
         count_q <= count_d;
      end
   end
endmodule : wdrt_stage

`default_nettype wire

// ==== verilog/wdrt_top.sv ====
`include "wdrt_defs.svh"
// Operation
// R1: Chain overflow asserts full device reset.
// R2: Interval programmable, quarter second to two.
// R3: Bit 7 enables counting, resets off.
// R4: Writing bit 6 high clears all stages.
// R5: Bit 5 routes around second stage.
// R6: Bit 4 routes around third stage.
// R7: Both bypassed: second stage still counts.
// R8: Bits 2:0 set first count 1..8.
// R9: Programming mode forces watchdog off.
// R10: Bit 3 reads zero; overflow resets fields.
`default_nettype none

module wdrt_top (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire wdrt_pkg::wdrt_addr_type addr_in,
   input wire wdrt_pkg::wdrt_byte_type wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic in_system_programming_mode_in,
   output wdrt_pkg::wdrt_byte_type rdata_out,
   output logic watchdog_reset_out
);
   import wdrt_pkg::*;

   localparam int BASE_CYCLES = `WDRT_BASE_TICK_CYCLES;
   localparam logic [11:0] BASE_LAST = 12'(BASE_CYCLES - 1);
   localparam int HOLD_CYCLES = `WDRT_RESET_HOLD_CYCLES;
   localparam logic [4:0] HOLD_LAST = 5'(HOLD_CYCLES - 1);

   // Control fields.
   logic watchdog_enable_q;
   logic bypass_second_stage_q;
   logic bypass_third_stage_q;
   logic [2:0] first_stage_count_q;

   // Programming-mode pin synchroniser.
   logic isp_meta_q;
   logic isp_sync_q;

   // Base tick prescaler and reset pulse state.
   logic [11:0] base_cnt_q;
   logic base_tick_q;
   wdrt_state_type state_q;
   wdrt_state_type state_d;
   logic [4:0] hold_cnt_q;
   logic reset_q;
   wdrt_byte_type rdata_q;

   // Decoded bus events.
   logic ctrl_sel;
   logic stat_sel;
   logic ctrl_wr;
   logic clear_req;
   logic active;
   logic chain_clear;
   logic firing;
   logic fire_next;
   wdrt_byte_type ctrl_view;
   wdrt_byte_type stat_view;
   wdrt_byte_type rdata_d;

   // Chain ticks.
   logic first_tick;
   logic second_tick;
   logic third_tick;
   logic third_mid_tick;
   logic into_third;
   logic overflow;
   logic skip_second;
   wdrt_count_type first_mod;

   // Address decode and write effects.
   assign ctrl_sel = (addr_in == `WDRT_CTRL_ADDR);
   assign stat_sel = (addr_in == `WDRT_STAT_ADDR);
   assign ctrl_wr = wr_in & ctrl_sel;
   assign clear_req = ctrl_wr & wdata_in[`WDRT_CLR_BIT]; // [R4]

   // The watchdog runs only when enabled and not in programming mode.
   assign active = watchdog_enable_q & ~isp_sync_q; // [R3] [R9]
   assign firing = (state_q == WDRT_ST_FIRE);
   assign fire_next = (state_d == WDRT_ST_FIRE); // [R1]

   // Counters restart on a clear, while idle, and while a reset is out.
   assign chain_clear = clear_req | ~active | firing; // [R4]

   // First stage modulus is the field plus one, giving 1 to 8.
   assign first_mod = {5'h00, first_stage_count_q} + 8'h01; // [R8]

   // With both bypass bits set only the third stage is skipped.
   assign skip_second = bypass_second_stage_q & ~bypass_third_stage_q; // [R7]
   assign into_third = skip_second ? first_tick : second_tick; // [R5]
   assign overflow = bypass_third_stage_q ? into_third : third_tick; // [R6]

   // Read views; the reserved bit and the write-only clear read zero.
   assign ctrl_view = {watchdog_enable_q, 1'b0, bypass_second_stage_q,
                       bypass_third_stage_q, 1'b0,
                       first_stage_count_q}; // [R10]
   assign stat_view = {5'h00, firing, isp_sync_q, active};
   assign rdata_d = !rd_in ? `WDRT_RDATA_RESET :
                    ctrl_sel ? ctrl_view :
                    stat_sel ? stat_view : `WDRT_RDATA_RESET;

   // Reset pulse sequencing: one overflow starts a fixed-length pulse.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         WDRT_ST_RUN: begin
            if (overflow && active) begin
               state_d = WDRT_ST_FIRE; // [R1]
            end
         end
         WDRT_ST_FIRE: begin
            if (hold_cnt_q == HOLD_LAST) begin
               state_d = WDRT_ST_RUN;
            end
         end
      endcase
   end

   // Two flops on the programming-mode pin before any use.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         isp_meta_q <= 1'b0;
         isp_sync_q <= 1'b0;
      end else if (ce_in) begin
         isp_meta_q <= in_system_programming_mode_in;
         isp_sync_q <= isp_meta_q; // [R9]
      end
   end

   // Control register; a watchdog reset returns it to its reset value.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {watchdog_enable_q, bypass_second_stage_q, bypass_third_stage_q,
          first_stage_count_q} <= 6'h00; // [R3]
      end else if (ce_in) begin
         if (firing || fire_next) begin
            {watchdog_enable_q, bypass_second_stage_q, bypass_third_stage_q,
             first_stage_count_q} <= 6'h00; // [R10]
         end else if (ctrl_wr) begin
            watchdog_enable_q <= wdata_in[`WDRT_EN_BIT]; // [R3]
            bypass_second_stage_q <= wdata_in[`WDRT_BYP2_BIT]; // [R5]
            bypass_third_stage_q <= wdata_in[`WDRT_BYP3_BIT]; // [R6]
            first_stage_count_q <=
               wdata_in[`WDRT_FIRST_STAGE_COUNT_MSB:`WDRT_FIRST_STAGE_COUNT_LSB]; // [R8]
         end
      end
   end

   // Base tick prescaler feeding the first stage.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         base_cnt_q <= 12'h000;
         base_tick_q <= 1'b0;
      end else if (ce_in) begin
         if (chain_clear) begin
            base_cnt_q <= 12'h000; // [R4]
            base_tick_q <= 1'b0;
         end else if (base_cnt_q == BASE_LAST) begin
            base_cnt_q <= 12'h000; // [R2]
            base_tick_q <= 1'b1;
         end else begin
            base_cnt_q <= base_cnt_q + 12'h001;
            base_tick_q <= 1'b0;
         end
      end
   end

   // First stage divides by the programmed count.
   wdrt_stage u_first (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .clear_in(chain_clear),
      .tick_in(base_tick_q & active),
      .modulus_in(first_mod),
      .tick_out(first_tick)
   );

   // Second stage.
   wdrt_stage u_second (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .clear_in(chain_clear),
      .tick_in(first_tick),
      .modulus_in(`WDRT_STAGE2_MOD),
      .tick_out(second_tick)
   );

   // Third stage, lower divider; one byte-wide counter is too narrow.
   wdrt_stage u_third (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .clear_in(chain_clear),
      .tick_in(into_third),
      .modulus_in(`WDRT_STAGE3_MOD),
      .tick_out(third_mid_tick)
   );

   // Third stage, upper divider; the pair is bypassed as one. [R6]
   wdrt_stage u_third_hi (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .clear_in(chain_clear),
      .tick_in(third_mid_tick),
      .modulus_in(`WDRT_STAGE3_MOD),
      .tick_out(third_tick)
   );

   // Reset pulse state and its length counter.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= WDRT_ST_RUN;
         hold_cnt_q <= 5'h00;
      end else if (ce_in) begin
         state_q <= state_d;
         hold_cnt_q <= firing ? hold_cnt_q + 5'h01 : 5'h00;
      end
   end

   // Registered outputs: the reset line and the read data.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reset_q <= 1'b0;
         rdata_q <= `WDRT_RDATA_RESET;
      end else if (ce_in) begin
         reset_q <= fire_next; // [R1]
         rdata_q <= rdata_d;
      end
   end

   assign watchdog_reset_out = reset_q;
   assign rdata_out = rdata_q;
endmodule : wdrt_top

`default_nettype wire
